// >>> rtl/stl_pkg.sv
// stl_pkg: codes, timing and carrier types for the layer-1 activation machine
package stl_pkg;
   localparam logic [3:0] CMD_DEACTIVATION_REQUEST       = 4'h0;
   localparam logic [3:0] CMD_COMMAND_RESET              = 4'h1;
   localparam logic [3:0] CMD_SINGLE_PULSE_TEST          = 4'h2;
   localparam logic [3:0] CMD_CONTINUOUS_PULSE_TEST      = 4'h3;
   localparam logic [3:0] CMD_RESYNC                     = 4'h4;
   localparam logic [3:0] CMD_ACTIVATION_REQUEST         = 4'h8;
   localparam logic [3:0] CMD_LOOP_ACTIVATION_REQUEST    = 4'hA;
   localparam logic [3:0] CMD_ACTIVATION_INDICATION      = 4'hC;
   localparam logic [3:0] CMD_LOOP_ACTIVATION_INDICATION = 4'hE;
   localparam logic [3:0] CMD_DEACTIVATION_CONFIRM       = 4'hF;
   localparam logic [3:0] IND_TIMING_INDICATION          = 4'h0;
   localparam logic [3:0] IND_RESYNC_INDICATION          = 4'h4;
   localparam logic [3:0] IND_ACTIVATION_REQUEST         = 4'h8;
   localparam logic [3:0] IND_CODE_VIOLATION_REPORT      = 4'hB;
   localparam logic [3:0] IND_ACTIVATION_INDICATION      = 4'hC;
   localparam logic [3:0] IND_DEACTIVATION_INDICATION    = 4'hF;
   localparam logic [5:0] CI_FIRST_BIT   = 6'h1A;
   localparam logic [5:0] CI_LAST_BIT    = 6'h1D;
   localparam logic [5:0] CI_DONE_BIT    = 6'h1E;
   localparam logic [2:0] CV_REPEAT      = 3'h6;
   localparam int SYS_CLK_NS       = 40;
   localparam int DEACT_TIMER_US   = 32000;
   localparam int DEACT_TIMER_CYC  = (DEACT_TIMER_US * 1000) / SYS_CLK_NS;
   localparam int SGL_RATE_HZ      = 2000;
   localparam int SGL_PERIOD_CYC   = 1000000000 / (SGL_RATE_HZ * SYS_CLK_NS);
   localparam int CONT_RATE_HZ     = 96000;
   localparam int CONT_PERIOD_CYC  = 1000000000 / (CONT_RATE_HZ * SYS_CLK_NS);
   localparam int PULSE_NS         = 5208;
   localparam int PULSE_CYC        = (PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam logic [1:0] TX_INFO0 = 2'h0;
   localparam logic [1:0] TX_INFO2 = 2'h1;
   localparam logic [1:0] TX_INFO4 = 2'h2;
   localparam logic [1:0] TX_PULSE = 2'h3;

   typedef enum logic [3:0] {
      ST_RESET    = 4'b0000,
      ST_DEACT    = 4'b0001,
      ST_I0DET    = 4'b0010,
      ST_PACT     = 4'b0011,
      ST_WAIT_SW  = 4'b0100,
      ST_ACTIVE   = 4'b0101,
      ST_LOST_ST  = 4'b0110,
      ST_LOST_UP  = 4'b0111,
      ST_PDEACT   = 4'b1000,
      ST_WAIT_CNF = 4'b1001,
      ST_TEST1    = 4'b1010,
      ST_TEST2    = 4'b1011
   } stl_state_t;

   typedef struct packed {
      logic info0;
      logic info3;
      logic rx_sync;
      logic level;
      logic code_viol;
   } stl_line_t;

   typedef struct packed {
      logic [1:0] info;
      logic       awake_en;
      logic       loop2;
      logic       pulse_p;
      logic       pulse_n;
   } stl_tx_t;
endpackage

// >>> rtl/stl_ci_rx.sv
// stl_ci_rx: frame bit counter and command field receiver with double look
`timescale 1ns/100ps
module stl_ci_rx (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       dcl,
   input  wire logic       fsc,
   input  wire logic       dd,
   output logic [3:0] code_r,
   output logic       code_vld_r,
   output logic       bit_go_r,
   output logic [5:0] bit_cnt_r,
   output logic       frame_end_r
);
   logic [2:0] m_r;
   logic [2:0] s_r;
   logic       dcl_d_r;
   logic [3:0] shift_r;
   logic [3:0] prev_r;
   logic       have_r;
   logic       rise;
   logic       fall;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         m_r     <= 3'h0;
         s_r     <= 3'h0;
         dcl_d_r <= 1'b0;
      end else begin
         m_r     <= {dcl, fsc, dd};
         s_r     <= m_r;
         dcl_d_r <= s_r[2];
      end
   end

   assign rise = s_r[2] & ~dcl_d_r;
   assign fall = ~s_r[2] & dcl_d_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bit_cnt_r   <= 6'h3F;
         bit_go_r    <= 1'b0;
         frame_end_r <= 1'b0;
      end else begin
         bit_go_r    <= rise;
         frame_end_r <= rise && !s_r[1] && bit_cnt_r == stl_pkg::CI_LAST_BIT;
         if (rise) begin
            // saturate so a missing frame sync never wraps into the field
            bit_cnt_r <= s_r[1] ? 6'h0 : (bit_cnt_r == 6'h3F ? 6'h3F : 6'(bit_cnt_r + 6'h1));
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         shift_r    <= 4'h0;
         prev_r     <= 4'h0;
         have_r     <= 1'b0;
         code_r     <= 4'h0;
         code_vld_r <= 1'b0;
      end else begin
         if (fall && bit_cnt_r >= stl_pkg::CI_FIRST_BIT && bit_cnt_r <= stl_pkg::CI_LAST_BIT) begin
            shift_r <= {shift_r[2:0], s_r[0]};
         end
         if (frame_end_r) begin
            prev_r <= shift_r;
            have_r <= 1'b1;
            // the cleared previous code must not pair with a first frame of 0000
            if (have_r && shift_r == prev_r) begin
               code_r     <= shift_r;
               code_vld_r <= 1'b1;
            end
         end
      end
   end
endmodule

// >>> rtl/stl_pulse_gen.sv
// stl_pulse_gen: alternating polarity test pulses at a selectable rate
`timescale 1ns/100ps
module stl_pulse_gen #(
   parameter int SGL_CYC = stl_pkg::SGL_PERIOD_CYC
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic en,
   input  wire logic cont,
   output logic      pos_r,
   output logic      neg_r
);
   logic [15:0] cnt_r;
   logic        pol_r;
   logic [15:0] last;
   logic        on;

   assign last = cont ? 16'(stl_pkg::CONT_PERIOD_CYC - 1) : 16'(SGL_CYC - 1);
   assign on   = en && cnt_r < 16'(stl_pkg::PULSE_CYC);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_r <= 16'h0;
         pol_r <= 1'b0;
         pos_r <= 1'b0;
         neg_r <= 1'b0;
      end else begin
         if (!en || cnt_r >= last) begin
            cnt_r <= 16'h0;
         end else begin
            cnt_r <= 16'(cnt_r + 16'h1);
         end
         if (en && cnt_r >= last) begin
            pol_r <= ~pol_r;
         end
         pos_r <= on && pol_r;
         neg_r <= on && !pol_r;
      end
   end
endmodule

// >>> rtl/stl_l1_fsm.sv
// stl_l1_fsm: exchange-side and network-side layer-1 activation state machine
`timescale 1ns/100ps
module stl_l1_fsm #(
   parameter int DEACT_CYC = stl_pkg::DEACT_TIMER_CYC,
   parameter int SGL_CYC   = stl_pkg::SGL_PERIOD_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              iom_dcl,
   input  wire logic              iom_fsc,
   input  wire logic              iom_dd,
   output logic                   iom_du_o,
   output logic                   iom_du_oe,
   input  wire stl_pkg::stl_line_t line_st,
   input  wire logic              network_termination_mode,
   input  wire logic              code_violation_report_enable,
   output stl_pkg::stl_tx_t       tx_r
);
   stl_pkg::stl_line_t line_m_r;
   stl_pkg::stl_line_t line_s_r;
   logic [1:0]         mode_m_r;
   logic [1:0]         mode_s_r;
   logic               netterm;
   logic               cv_en;
   logic [3:0]         ci_code;
   logic               ci_vld;
   logic               bit_go;
   logic [5:0]         bit_cnt;
   logic               frame_end;
   stl_pkg::stl_state_t st_r;
   stl_pkg::stl_state_t st_nxt;
   logic               loop_r;
   logic [19:0]        deact_cnt_r;
   logic               timer_done;
   logic [2:0]         cv_cnt_r;
   logic [3:0]         ind_nxt;
   logic [3:0]         ind_r;
   logic               pls_p;
   logic               pls_n;

   // line status and strap pins come from the analog front end, not this clock
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         line_m_r <= '0;
         line_s_r <= '0;
         mode_m_r <= 2'h0;
         mode_s_r <= 2'h0;
      end else begin
         line_m_r <= line_st;
         line_s_r <= line_m_r;
         mode_m_r <= {network_termination_mode, code_violation_report_enable};
         mode_s_r <= mode_m_r;
      end
   end

   assign netterm = mode_s_r[1];
   assign cv_en   = mode_s_r[0];

   stl_ci_rx u_rx (
      .sys_clk     (sys_clk),
      .sys_rst     (sys_rst),
      .dcl         (iom_dcl),
      .fsc         (iom_fsc),
      .dd          (iom_dd),
      .code_r      (ci_code),
      .code_vld_r  (ci_vld),
      .bit_go_r    (bit_go),
      .bit_cnt_r   (bit_cnt),
      .frame_end_r (frame_end)
   );

   // commands defined in the current mode; others leave the state alone
   function automatic logic cmd_known(input logic [3:0] c, input logic ntm);
      case (c)
         stl_pkg::CMD_DEACTIVATION_REQUEST,
         stl_pkg::CMD_COMMAND_RESET,
         stl_pkg::CMD_SINGLE_PULSE_TEST,
         stl_pkg::CMD_CONTINUOUS_PULSE_TEST,
         stl_pkg::CMD_ACTIVATION_REQUEST,
         stl_pkg::CMD_LOOP_ACTIVATION_REQUEST,
         stl_pkg::CMD_DEACTIVATION_CONFIRM: return 1'b1;
         stl_pkg::CMD_RESYNC,
         stl_pkg::CMD_ACTIVATION_INDICATION,
         stl_pkg::CMD_LOOP_ACTIVATION_INDICATION: return ntm;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic cmd_is(input logic [3:0] c);
      return ci_vld && cmd_known(ci_code, netterm) && ci_code == c;
   endfunction

   // commands are levels held by upstream, so each branch is safe to repeat
   always_comb begin
      st_nxt = st_r;
      if (cmd_is(stl_pkg::CMD_COMMAND_RESET)) begin
         st_nxt = stl_pkg::ST_RESET;
      end else if (cmd_is(stl_pkg::CMD_DEACTIVATION_REQUEST) &&
                   st_r != stl_pkg::ST_PDEACT && st_r != stl_pkg::ST_WAIT_CNF) begin
         st_nxt = stl_pkg::ST_PDEACT;
      end else if (cmd_is(stl_pkg::CMD_SINGLE_PULSE_TEST)) begin
         st_nxt = stl_pkg::ST_TEST1;
      end else if (cmd_is(stl_pkg::CMD_CONTINUOUS_PULSE_TEST)) begin
         st_nxt = stl_pkg::ST_TEST2;
      end else begin
         case (st_r)
            stl_pkg::ST_RESET,
            stl_pkg::ST_TEST1,
            stl_pkg::ST_TEST2,
            stl_pkg::ST_WAIT_CNF: begin
               if (cmd_is(stl_pkg::CMD_DEACTIVATION_CONFIRM)) begin
                  st_nxt = stl_pkg::ST_DEACT;
               end
            end
            stl_pkg::ST_DEACT: begin
               if (cmd_is(stl_pkg::CMD_ACTIVATION_REQUEST) ||
                   cmd_is(stl_pkg::CMD_LOOP_ACTIVATION_REQUEST)) begin
                  st_nxt = stl_pkg::ST_PACT;
               end else if (line_s_r.info0) begin
                  st_nxt = netterm ? stl_pkg::ST_I0DET : stl_pkg::ST_PACT;
               end
            end
            stl_pkg::ST_I0DET: begin
               if (cmd_is(stl_pkg::CMD_ACTIVATION_REQUEST) ||
                   cmd_is(stl_pkg::CMD_LOOP_ACTIVATION_REQUEST)) begin
                  st_nxt = stl_pkg::ST_PACT;
               end
            end
            stl_pkg::ST_PACT: begin
               // no timeout here: upstream supervises the INFO 3 wait
               if (line_s_r.info3) begin
                  st_nxt = netterm ? stl_pkg::ST_WAIT_SW : stl_pkg::ST_ACTIVE;
               end
            end
            stl_pkg::ST_WAIT_SW,
            stl_pkg::ST_LOST_UP: begin
               if (cmd_is(stl_pkg::CMD_ACTIVATION_INDICATION)) begin
                  st_nxt = stl_pkg::ST_ACTIVE;
               end
            end
            stl_pkg::ST_ACTIVE: begin
               if (cmd_is(stl_pkg::CMD_RESYNC)) begin
                  st_nxt = stl_pkg::ST_LOST_UP;
               end else if (!line_s_r.rx_sync) begin
                  st_nxt = stl_pkg::ST_LOST_ST;
               end
            end
            stl_pkg::ST_LOST_ST: begin
               if (line_s_r.info3) begin
                  st_nxt = stl_pkg::ST_ACTIVE;
               end
            end
            stl_pkg::ST_PDEACT: begin
               if (line_s_r.info0 || timer_done) begin
                  st_nxt = stl_pkg::ST_WAIT_CNF;
               end
            end
            default: st_nxt = stl_pkg::ST_RESET;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= stl_pkg::ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // loop 2 closes on the loop command and opens once the line is torn down
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         loop_r <= 1'b0;
      end else if (st_nxt == stl_pkg::ST_RESET || st_nxt == stl_pkg::ST_DEACT ||
                   st_nxt == stl_pkg::ST_PDEACT) begin
         loop_r <= 1'b0;
      end else if (cmd_is(stl_pkg::CMD_LOOP_ACTIVATION_REQUEST) &&
                   (st_r == stl_pkg::ST_DEACT || st_r == stl_pkg::ST_I0DET ||
                    st_r == stl_pkg::ST_PACT)) begin
         loop_r <= 1'b1;
      end else if (cmd_is(stl_pkg::CMD_LOOP_ACTIVATION_INDICATION) && st_r == stl_pkg::ST_ACTIVE) begin
         loop_r <= 1'b1;
      end
   end

   assign timer_done = deact_cnt_r == 20'(DEACT_CYC - 1);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         deact_cnt_r <= 20'h0;
      end else if (st_r == stl_pkg::ST_PDEACT && !timer_done) begin
         deact_cnt_r <= 20'(deact_cnt_r + 20'h1);
      end else if (st_r != stl_pkg::ST_PDEACT) begin
         deact_cnt_r <= 20'h0;
      end
   end

   // a new violation reloads the count even on the frame that would decrement it
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cv_cnt_r <= 3'h0;
      end else if (cv_en && line_s_r.code_viol) begin
         cv_cnt_r <= stl_pkg::CV_REPEAT;
      end else if (frame_end && cv_cnt_r != 3'h0) begin
         cv_cnt_r <= 3'(cv_cnt_r - 3'h1);
      end
   end

   always_comb begin
      case (st_r)
         stl_pkg::ST_PDEACT,
         stl_pkg::ST_TEST1,
         stl_pkg::ST_TEST2: ind_nxt = stl_pkg::IND_TIMING_INDICATION;
         stl_pkg::ST_DEACT: begin
            if (netterm && line_s_r.level) begin
               ind_nxt = stl_pkg::IND_TIMING_INDICATION;
            end else begin
               ind_nxt = stl_pkg::IND_DEACTIVATION_INDICATION;
            end
         end
         stl_pkg::ST_I0DET,
         stl_pkg::ST_WAIT_SW: ind_nxt = stl_pkg::IND_ACTIVATION_REQUEST;
         stl_pkg::ST_PACT: begin
            ind_nxt = netterm ? stl_pkg::IND_RESYNC_INDICATION : stl_pkg::IND_ACTIVATION_REQUEST;
         end
         stl_pkg::ST_ACTIVE: begin
            if (cv_cnt_r != 3'h0) begin
               ind_nxt = stl_pkg::IND_CODE_VIOLATION_REPORT;
            end else if (line_s_r.rx_sync) begin
               ind_nxt = stl_pkg::IND_ACTIVATION_INDICATION;
            end else begin
               ind_nxt = stl_pkg::IND_RESYNC_INDICATION;
            end
         end
         stl_pkg::ST_LOST_ST: ind_nxt = stl_pkg::IND_RESYNC_INDICATION;
         stl_pkg::ST_LOST_UP: ind_nxt = stl_pkg::IND_ACTIVATION_INDICATION;
         default: ind_nxt = stl_pkg::IND_DEACTIVATION_INDICATION;
      endcase
   end

   // latch once per frame so the field never changes while it is shifted out
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ind_r <= stl_pkg::IND_DEACTIVATION_INDICATION;
      end else if (frame_end) begin
         ind_r <= ind_nxt;
      end
   end

   // open drain: only zeros are driven, ones come from the pull-up
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         iom_du_o  <= 1'b0;
         iom_du_oe <= 1'b0;
      end else begin
         iom_du_o <= 1'b0;
         if (bit_go) begin
            iom_du_oe <= bit_cnt >= stl_pkg::CI_FIRST_BIT && bit_cnt <= stl_pkg::CI_LAST_BIT &&
                         !ind_r[2'(stl_pkg::CI_LAST_BIT - bit_cnt)];
         end
      end
   end

   stl_pulse_gen #(
      .SGL_CYC (SGL_CYC)
   ) u_pulse (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .en      (st_r == stl_pkg::ST_TEST1 || st_r == stl_pkg::ST_TEST2),
      .cont    (st_r == stl_pkg::ST_TEST2),
      .pos_r   (pls_p),
      .neg_r   (pls_n)
   );

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_r <= '0;
      end else begin
         tx_r.awake_en <= st_r != stl_pkg::ST_RESET;
         tx_r.loop2    <= loop_r;
         tx_r.pulse_p  <= pls_p;
         tx_r.pulse_n  <= pls_n;
         case (st_r)
            stl_pkg::ST_PACT,
            stl_pkg::ST_WAIT_SW,
            stl_pkg::ST_LOST_ST,
            stl_pkg::ST_LOST_UP: tx_r.info <= stl_pkg::TX_INFO2;
            stl_pkg::ST_ACTIVE:  tx_r.info <= stl_pkg::TX_INFO4;
            stl_pkg::ST_TEST1,
            stl_pkg::ST_TEST2:   tx_r.info <= stl_pkg::TX_PULSE;
            default:             tx_r.info <= stl_pkg::TX_INFO0;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_pdeact_end;
      st_r == stl_pkg::ST_PDEACT && (line_s_r.info0 || timer_done);
   endsequence

   sequence s_plain_cycle;
      !ci_vld || !cmd_known(ci_code, netterm);
   endsequence

   sequence s_no_override;
      !cmd_is(stl_pkg::CMD_COMMAND_RESET) && !cmd_is(stl_pkg::CMD_SINGLE_PULSE_TEST) &&
      !cmd_is(stl_pkg::CMD_CONTINUOUS_PULSE_TEST);
   endsequence

   cmd_reset_idle_a: assert property (
      cmd_is(stl_pkg::CMD_COMMAND_RESET) |=> st_r == stl_pkg::ST_RESET ##1 !tx_r.awake_en &&
      tx_r.info == stl_pkg::TX_INFO0)
      else $error("reset command did not idle the line");

   dr_accept_a: assert property (
      cmd_is(stl_pkg::CMD_DEACTIVATION_REQUEST) && st_r != stl_pkg::ST_WAIT_CNF
      |=> st_r == stl_pkg::ST_PDEACT || st_r == stl_pkg::ST_WAIT_CNF)
      else $error("deactivation request not accepted");

   deact_quiet_a: assert property (
      st_r == stl_pkg::ST_DEACT |=> tx_r.info == stl_pkg::TX_INFO0)
      else $error("deactivated state is transmitting");

   pend_info2_a: assert property (
      st_r == stl_pkg::ST_PACT ##1 st_r == stl_pkg::ST_PACT |-> tx_r.info == stl_pkg::TX_INFO2)
      else $error("pending activation not sending INFO 2");

   lost_frame_a: assert property (
      st_r == stl_pkg::ST_ACTIVE && !line_s_r.rx_sync ##0 s_plain_cycle
      |=> st_r == stl_pkg::ST_LOST_ST ##1 tx_r.info == stl_pkg::TX_INFO2)
      else $error("loss of sync did not fall back to INFO 2");

   pdeact_end_a: assert property (
      s_pdeact_end ##0 s_no_override |=> st_r == stl_pkg::ST_WAIT_CNF)
      else $error("pending deactivation did not end");

   wait_cnf_hold_a: assert property (
      st_r == stl_pkg::ST_WAIT_CNF && !cmd_is(stl_pkg::CMD_DEACTIVATION_CONFIRM) ##0 s_no_override
      |=> st_r == stl_pkg::ST_WAIT_CNF)
      else $error("final wait left without a command");

   cv_report_a: assert property (
      cv_en && line_s_r.code_viol && st_r == stl_pkg::ST_ACTIVE && st_nxt == stl_pkg::ST_ACTIVE
      |=> cv_cnt_r == stl_pkg::CV_REPEAT)
      else $error("code violation count not loaded");

   ignore_undef_a: assert property (
      ci_vld && !cmd_known(ci_code, netterm) && st_r != stl_pkg::ST_PDEACT &&
      st_r != stl_pkg::ST_DEACT && st_r != stl_pkg::ST_PACT && st_r != stl_pkg::ST_ACTIVE
      && st_r != stl_pkg::ST_LOST_ST |=> $stable(st_r))
      else $error("undefined command changed the state");
endmodule

// >>> verif/stl_iom_host.sv
// stl_iom_host: upstream controller model driving the frame link
`timescale 1ns/100ps
module stl_iom_host (
   output logic            dcl,
   output logic            fsc,
   output logic            dd,
   input  wire logic       du,
   input  wire logic [3:0] cmd,
   output logic [3:0]      ind,
   output int              frames
);
   int         b;
   logic [3:0] sh;
   // bit clock runs free, as the device needs it even during reset
   initial begin
      {dcl, fsc, dd, sh, ind} = '0;
      frames = 0;
      b = 31;
      #7;
      forever begin
         #160 dcl = 1'b1;
         // du is read a full bit late since the device answers well after the rise
         sh = {sh[2:0], du};
         if (b == 29) begin
            ind = sh;
            frames++;
         end
         b = (b + 1) % 32;
         // the command repeats in every frame until changed
         dd = (b > 25 && b < 30) ? cmd[29 - b] : b[0];
         #160 dcl = 1'b0;
         fsc = (b == 31);
      end
   end
endmodule

// >>> verif/test_st_layer1_activation_fsm.sv
// test_st_layer1_activation_fsm: scenario bench for the layer-1 activation machine
`timescale 1ns/100ps
module test_st_layer1_activation_fsm;
   localparam int DEACT = 2000;
   localparam int SGL   = 300;
   logic               sys_clk;
   logic               sys_rst;
   logic               dcl;
   logic               fsc;
   logic               dd;
   logic               du_o;
   logic               du_oe;
   logic               ntm;
   logic               cve;
   logic [3:0]         cmd;
   logic [3:0]         ind;
   int                 frames;
   int                 mismatches;
   int                 n_compared;
   stl_pkg::stl_line_t line;
   stl_pkg::stl_tx_t   tx;
   wire                du = du_oe ? du_o : 1'b1;

   stl_l1_fsm #(.DEACT_CYC(DEACT), .SGL_CYC(SGL)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .iom_dcl(dcl), .iom_fsc(fsc), .iom_dd(dd), .iom_du_o(du_o), .iom_du_oe(du_oe), .line_st(line),
      .network_termination_mode(ntm), .code_violation_report_enable(cve), .tx_r(tx));
   stl_iom_host host (.dcl(dcl), .fsc(fsc), .dd(dd), .du(du), .cmd(cmd), .ind(ind), .frames(frames));

   always #20 sys_clk = ~sys_clk;

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic note(input logic ok, input string s);
      n_compared++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("Error %0t %s", $time, s);
      end
   endtask
   task automatic chk_ind(input logic [3:0] e);
      note(ind === e, "indication");
   endtask
   task automatic chk_info(input logic [1:0] e);
      note(tx.info === e, "line signal");
   endtask
   task automatic chk_tx(input logic [5:0] e, input logic [5:0] m);
      note((tx & m) === e, "line outputs");
   endtask
   task automatic chk_cnt(input int g, input int e);
      note(g == e, "count");
   endtask
   task automatic frame_wait(input int n);
      int f;
      f = frames + n;
      repeat (n * 300) if (frames < f) @(posedge sys_clk);
      if (frames < f) begin
         note(1'b0, "frame timeout");
         end_of_test();
      end
   endtask
   // bounded like the controller's own supervision timer
   task automatic wait_ind(input logic [3:0] e);
      int k;
      for (k = 0; k < 3000 && ind !== e; k++) @(posedge sys_clk);
      chk_ind(e);
      if (k == 3000) end_of_test();
   endtask
   task automatic send(input logic [3:0] c, input logic [3:0] e);
      @(posedge sys_clk);
      cmd <= c;
      wait_ind(e);
   endtask
   task automatic lin(input logic [4:0] v);
      @(posedge sys_clk);
      line <= v;
   endtask
   task automatic t_pulse(input logic [3:0] c, input int e);
      int   n;
      int   sn;
      logic lp;
      send(c, 4'h0);
      frame_wait(3);
      chk_info(stl_pkg::TX_PULSE);
      // start on a rising edge, never in the middle of a pulse
      for (n = 0; n < 2000 && tx.pulse_p === 1'b1; n++) @(negedge sys_clk);
      for (n = 0; n < 2000 && tx.pulse_p !== 1'b1; n++) @(negedge sys_clk);
      n = 0;
      sn = 0;
      lp = 1'b1;
      while (n < 2000 && !(tx.pulse_p === 1'b1 && lp === 1'b0)) begin
         lp = tx.pulse_p;
         @(negedge sys_clk);
         n++;
         if (tx.pulse_n === 1'b1) sn = 1;
      end
      chk_cnt(n, e);
      chk_cnt(sn, 1);
   endtask

   task automatic t_activate();
      send(4'hF, 4'hF);
      frame_wait(3);
      chk_tx(6'h08, 6'h3F);
      send(4'h8, 4'h8);
      chk_info(stl_pkg::TX_INFO2);
      lin(5'h0E);
      wait_ind(4'hC);
      chk_info(stl_pkg::TX_INFO4);
      send(4'h5, 4'hC);
      frame_wait(3);
      chk_ind(4'hC);
      lin(5'h02);
      wait_ind(4'h4);
      chk_info(stl_pkg::TX_INFO2);
      lin(5'h0E);
      wait_ind(4'hC);
      chk_info(stl_pkg::TX_INFO4);
      $display("activation done");
   endtask
   task automatic t_violation();
      int n;
      cve <= 1'b1;
      frame_wait(1);
      lin(5'h0F);
      lin(5'h0E);
      wait_ind(4'hB);
      // counts frames showing the report; one reload gives a fixed run
      for (n = 0; n < 9 && ind === 4'hB; n++) frame_wait(1);
      chk_cnt(n, 6);
      $display("violation done");
   endtask
   task automatic t_deactivate();
      send(4'h0, 4'h0);
      chk_info(stl_pkg::TX_INFO0);
      frame_wait(4);
      chk_ind(4'h0);
      wait_ind(4'hF);
      frame_wait(3);
      chk_ind(4'hF);
      send(4'hF, 4'hF);
      frame_wait(3);
      chk_tx(6'h08, 6'h3F);
      send(4'h0, 4'h0);
      lin(5'h10);
      frame_wait(2);
      chk_ind(4'hF);
      $display("deactivation done");
   endtask
   task automatic t_wake();
      lin(5'h00);
      send(4'hF, 4'hF);
      frame_wait(3);
      lin(5'h10);
      wait_ind(4'h8);
      chk_info(stl_pkg::TX_INFO2);
      lin(5'h00);
      send(4'hA, 4'h8);
      frame_wait(3);
      chk_tx(6'h04, 6'h04);
      $display("wake done");
   endtask
   task automatic t_test_modes();
      t_pulse(4'h2, 2 * SGL);
      t_pulse(4'h3, 2 * stl_pkg::CONT_PERIOD_CYC);
      send(4'h1, 4'hF);
      chk_tx(6'h00, 6'h38);
      $display("test modes done");
   endtask
   task automatic t_network();
      ntm <= 1'b1;
      sys_rst <= 1'b1;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      chk_tx(6'h00, 6'h3F);
      send(4'hF, 4'hF);
      frame_wait(3);
      lin(5'h02);
      wait_ind(4'h0);
      lin(5'h00);
      send(4'h8, 4'h4);
      lin(5'h0E);
      wait_ind(4'h8);
      chk_info(stl_pkg::TX_INFO2);
      send(4'hC, 4'hC);
      chk_info(stl_pkg::TX_INFO4);
      send(4'h4, 4'hC);
      frame_wait(3);
      chk_info(stl_pkg::TX_INFO2);
      $display("network mode done");
   endtask

   initial begin
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      ntm = 1'b0;
      cve = 1'b0;
      cmd = 4'h5;
      line = '0;
      mismatches = 0;
      n_compared = 0;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      chk_tx(6'h00, 6'h3F);
      wait_ind(4'hF);
      t_activate();
      t_violation();
      t_deactivate();
      t_wake();
      t_test_modes();
      t_network();
      end_of_test();
   end
endmodule
